// ### shared/lm_pkg.sv
package lm_pkg;
  localparam int SAMPLE_W = 16;
  localparam int ACC_W = 27;
  localparam int CNT_W = 11;
  localparam int SHIFT_W = 4;
  localparam int TH_W = 3;
  localparam int NUM_CH = 4;
  localparam int CH_W = 2;
  localparam int COEF_FRAC = 14;
  localparam int GAIN_SHIFT = 4;
  localparam logic [SHIFT_W-1:0] SHIFT_MAX_CODE = 4'hB;
  localparam int TH_POS = 12;
  localparam logic signed [SAMPLE_W-1:0] RESULT_MAX = 16'sh7FFF;
  localparam logic signed [SAMPLE_W-1:0] RESULT_MIN = 16'sh8000;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int DONE_HOLD_NS = 125000;
  localparam int DONE_HOLD_CYC = DONE_HOLD_NS / CLK_PERIOD_NS;
  // Fixed filter coefficients, plain defaults in Q14
  localparam logic signed [15:0] NOTCH_ROM_COEF = 16'sh6000;
  localparam logic signed [15:0] BP_ROM_COEF = 16'sh6000;
  localparam logic signed [15:0] POLE_R2 = 16'sh3000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_HOLD = 2'b10
  } meter_state_e;

  function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
    if (v > 32'sd32767) begin
      sat16 = RESULT_MAX;
    end else if (v < -32'sd32768) begin
      sat16 = RESULT_MIN;
    end else begin
      sat16 = v[15:0];
    end
  endfunction : sat16

  function automatic logic signed [15:0] scale_sum(input logic signed [ACC_W-1:0] sum,
                                                   input logic [SHIFT_W-1:0] code);
    logic [SHIFT_W-1:0] sh;
    logic signed [ACC_W-1:0] shifted;
    sh = (code > SHIFT_MAX_CODE) ? SHIFT_MAX_CODE : code;
    shifted = sum >>> sh;
    scale_sum = sat16(32'(shifted));
  endfunction : scale_sum
endpackage : lm_pkg

// ### shared/lm_path_if.sv
interface lm_path_if;
  logic signed [15:0] sample;
  logic sample_valid;
  logic filter_enable;
  logic filter_shape_sel;
  logic notch_coef_src;
  logic bandpass_coef_src;
  logic gain_sel;
  logic rectifier_enable;
  logic offset_source_sel;
  logic signed [15:0] offset_word;
  logic signed [15:0] notch_coef;
  logic signed [15:0] bandpass_coef;
  logic signed [15:0] out_sample;
  logic out_valid;

  modport src (output sample, sample_valid, filter_enable, filter_shape_sel, notch_coef_src,
               bandpass_coef_src, gain_sel, rectifier_enable, offset_source_sel, offset_word,
               notch_coef, bandpass_coef, input out_sample, out_valid);
  modport dut (input sample, sample_valid, filter_enable, filter_shape_sel, notch_coef_src,
               bandpass_coef_src, gain_sel, rectifier_enable, offset_source_sel, offset_word,
               notch_coef, bandpass_coef, output out_sample, out_valid);
endinterface : lm_path_if

// ### rtl/lm_condition.sv
module lm_condition (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  lm_path_if.dut path
);
  import lm_pkg::*;

  logic signed [15:0] w1_r;
  logic signed [15:0] w2_r;
  logic signed [15:0] out_r;
  logic valid_r;
  logic signed [15:0] offset;
  logic signed [15:0] coef;
  logic signed [15:0] x;
  logic signed [15:0] w;
  logic signed [15:0] bp;
  logic signed [15:0] notch;
  logic signed [15:0] f;
  logic signed [15:0] g;
  logic signed [15:0] r;

  always_comb begin
    offset = path.offset_source_sel ? 16'sh0000 : path.offset_word;
    if (path.filter_shape_sel) begin
      coef = path.bandpass_coef_src ? BP_ROM_COEF : path.bandpass_coef;
    end else begin
      coef = path.notch_coef_src ? NOTCH_ROM_COEF : path.notch_coef;
    end
    x = sat16(32'(path.sample) - 32'(offset));
    w = sat16(32'(x) + ((32'(coef) * 32'(w1_r)) >>> COEF_FRAC) - ((32'(POLE_R2) * 32'(w2_r)) >>> COEF_FRAC));
    bp = sat16((32'(w) - 32'(w2_r)) >>> 1);
    notch = sat16(32'(x) - 32'(bp));
    // Filter bypassed when disabled, notch or bandpass otherwise
    f = path.filter_enable ? (path.filter_shape_sel ? bp : notch) : x;
    g = path.gain_sel ? sat16(32'(f) <<< GAIN_SHIFT) : f;
    // Negating full scale would wrap, so it saturates instead
    r = (path.rectifier_enable && g[15]) ? sat16(-32'(g)) : g;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      w1_r <= '0;
      w2_r <= '0;
    end else if (clk_en && path.sample_valid) begin
      w1_r <= w;
      w2_r <= w1_r;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_r <= '0;
      valid_r <= 1'b0;
    end else if (clk_en) begin
      valid_r <= path.sample_valid;
      if (path.sample_valid) begin
        out_r <= r;
      end
    end
  end

  assign path.out_sample = out_r;
  assign path.out_valid = valid_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  rect_positive_a: assert property ((clk_en && path.sample_valid && path.rectifier_enable) |=> !out_r[15])
    else $error("rectified sample negative");
endmodule : lm_condition

// ### rtl/level_meter_result_unit.sv
// Behaviour
// - Result is 16-bit, low and high bytes
// - Two's complement codes, saturate at full scale
// - 27-bit accumulator scaled into 16-bit result
// - Shift code halves factor, capped at 1/2048
// - Over-threshold flag when magnitude exceeds threshold
// - Threshold code steps 12.5 percent full scale
// - Count field sets 1 to 2048 samples
// - Channel select picks one of four
// - Filter bypass or insert, notch or bandpass
// - Coefficients from RAM or fixed ROM
// - Enable rise starts, enable low stops
// - Completion flag set after each period
// - Extra gain of 1 or 16
// - Rectifier folds negative samples or passes
// - Mode picks single or continuous integration
// - Offset from RAM word or zero
// - Continuous restarts; flag self-clears after 125 us
// - Single mode holds flag; restart needs rise
// - Rectifier bit high enables rectifier
// - Results cleared while meter disabled
module level_meter_result_unit #(
  parameter int DONE_HOLD = lm_pkg::DONE_HOLD_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic sample_tick,
  input wire logic signed [15:0] ac_sample [lm_pkg::NUM_CH],
  input wire logic signed [15:0] dc_tx_sample [lm_pkg::NUM_CH],
  input wire logic signed [15:0] dc_rx_sample [lm_pkg::NUM_CH],
  input wire logic [lm_pkg::CH_W-1:0] meter_channel_sel,
  input wire logic ac_source_sel,
  input wire logic dc_path_sel,
  input wire logic filter_enable,
  input wire logic filter_shape_sel,
  input wire logic notch_coef_src,
  input wire logic bandpass_coef_src,
  input wire logic gain_sel,
  input wire logic rectifier_enable,
  input wire logic offset_source_sel,
  input wire logic signed [15:0] offset_word,
  input wire logic signed [15:0] notch_coef,
  input wire logic signed [15:0] bandpass_coef,
  input wire logic single_mode,
  input wire logic meter_enable,
  input wire logic [lm_pkg::CNT_W-1:0] integration_count,
  input wire logic [lm_pkg::SHIFT_W-1:0] shift_code,
  input wire logic [lm_pkg::TH_W-1:0] threshold_code,
  output logic [7:0] meter_result_low,
  output logic [7:0] meter_result_high,
  output logic measure_done_flag,
  output logic over_threshold_flag
);
  import lm_pkg::*;

  lm_path_if path ();

  meter_state_e state_r;
  meter_state_e state_nxt;
  logic en_q_r;
  logic en_rise;
  logic signed [ACC_W-1:0] acc_r;
  logic signed [ACC_W-1:0] acc_total;
  logic [CNT_W-1:0] cnt_r;
  logic period_end;
  logic signed [15:0] scaled;
  logic [16:0] magnitude;
  logic [16:0] threshold;
  logic [15:0] hold_cnt_r;
  logic signed [15:0] sample_r;
  logic valid_r;

  // Source mux is registered so the conditioning path sees a stable word
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sample_r <= '0;
      valid_r <= 1'b0;
    end else if (clk_en) begin
      valid_r <= sample_tick;
      if (sample_tick) begin
        if (ac_source_sel) begin
          sample_r <= ac_sample[meter_channel_sel];
        end else if (dc_path_sel) begin
          sample_r <= dc_tx_sample[meter_channel_sel];
        end else begin
          sample_r <= dc_rx_sample[meter_channel_sel];
        end
      end
    end
  end

  assign path.sample = sample_r;
  assign path.sample_valid = valid_r;
  assign path.filter_enable = filter_enable;
  assign path.filter_shape_sel = filter_shape_sel;
  assign path.notch_coef_src = notch_coef_src;
  assign path.bandpass_coef_src = bandpass_coef_src;
  assign path.gain_sel = gain_sel;
  assign path.rectifier_enable = rectifier_enable;
  assign path.offset_source_sel = offset_source_sel;
  assign path.offset_word = offset_word;
  assign path.notch_coef = notch_coef;
  assign path.bandpass_coef = bandpass_coef;

  lm_condition u_condition (
    .clk(clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .path(path.dut)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      en_q_r <= 1'b0;
    end else if (clk_en) begin
      en_q_r <= meter_enable;
    end
  end

  assign en_rise = meter_enable && !en_q_r;
  // Count field N gives N+1 samples, one sample per 0.125 ms
  assign period_end = (state_r == ST_RUN) && path.out_valid && (cnt_r == integration_count);
  assign acc_total = acc_r + ACC_W'(path.out_sample);
  assign scaled = scale_sum(acc_total, shift_code);
  assign magnitude = scaled[15] ? (17'h10000 - {1'b0, 16'(scaled)}) : {1'b0, 16'(scaled)};
  assign threshold = 17'({threshold_code, 12'h000});

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (en_rise) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!meter_enable) begin
          state_nxt = ST_IDLE;
        end else if (period_end && single_mode) begin
          state_nxt = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!meter_enable) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_r <= '0;
      cnt_r <= '0;
    end else if (clk_en) begin
      if (state_r != ST_RUN) begin
        acc_r <= '0;
        cnt_r <= '0;
      end else if (period_end) begin
        acc_r <= '0;
        cnt_r <= '0;
      end else if (path.out_valid) begin
        acc_r <= acc_total;
        cnt_r <= cnt_r + 11'h001;
      end
    end
  end

  // Both bytes load in one edge, so a read never mixes two periods
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meter_result_low <= RESULT_RESET[7:0];
      meter_result_high <= RESULT_RESET[15:8];
    end else if (clk_en) begin
      if (!meter_enable) begin
        meter_result_low <= RESULT_RESET[7:0];
        meter_result_high <= RESULT_RESET[15:8];
      end else if (period_end) begin
        meter_result_low <= scaled[7:0];
        meter_result_high <= scaled[15:8];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      over_threshold_flag <= 1'b0;
    end else if (clk_en) begin
      if (!meter_enable) begin
        over_threshold_flag <= 1'b0;
      end else if (period_end) begin
        over_threshold_flag <= (magnitude > threshold);
      end
    end
  end

  // A new completion wins over the timed self-clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      measure_done_flag <= 1'b0;
      hold_cnt_r <= '0;
    end else if (clk_en) begin
      if (!meter_enable) begin
        measure_done_flag <= 1'b0;
        hold_cnt_r <= '0;
      end else if (period_end) begin
        measure_done_flag <= 1'b1;
        hold_cnt_r <= 16'(DONE_HOLD - 1);
      end else if (measure_done_flag && !single_mode) begin
        if (hold_cnt_r == 16'h0000) begin
          measure_done_flag <= 1'b0;
        end else begin
          hold_cnt_r <= hold_cnt_r - 16'h0001;
        end
      end
    end
  end

  logic [15:0] done_age_r;
  logic signed [15:0] scaled_q_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      done_age_r <= '0;
      scaled_q_r <= '0;
    end else begin
      scaled_q_r <= scaled;
      if (measure_done_flag && !single_mode && !(clk_en && period_end)) begin
        done_age_r <= (clk_en && done_age_r != 16'hFFFF) ? done_age_r + 16'h0001 : done_age_r;
      end else begin
        done_age_r <= '0;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_period_end;
    clk_en && period_end;
  endsequence

  sequence s_single_end;
    clk_en && period_end && single_mode && meter_enable;
  endsequence

  sequence s_hold_steady;
    clk_en && state_r == ST_HOLD && single_mode && meter_enable;
  endsequence

  results_cleared_a: assert property ((clk_en && !meter_enable) |=> {meter_result_high, meter_result_low} == 16'h0000)
    else $error("result not cleared while disabled");
  done_set_a: assert property ((s_period_end ##0 meter_enable) |=> measure_done_flag)
    else $error("completion flag not set");
  result_scaled_a: assert property (s_period_end ##0 meter_enable |=> {meter_result_high, meter_result_low} == scaled_q_r)
    else $error("result not scaled sum");
  bytes_atomic_a: assert property (($changed(meter_result_low) || $changed(meter_result_high))
      |-> $past(clk_en && (period_end || !meter_enable)))
    else $error("result bytes changed outside a latch");
  over_thr_a: assert property ((s_period_end ##0 meter_enable) |=> over_threshold_flag == $past(magnitude > threshold))
    else $error("over-threshold flag wrong");
  single_hold_a: assert property (s_single_end |=> measure_done_flag && state_r == ST_HOLD)
    else $error("single mode did not hold completion");
  single_stay_a: assert property (s_hold_steady |=> measure_done_flag && state_r == ST_HOLD)
    else $error("completion dropped in single mode");
  cont_restart_a: assert property ((s_period_end ##0 (!single_mode && meter_enable)) |=> state_r == ST_RUN && cnt_r == 11'h000)
    else $error("continuous mode did not restart");
  done_clear_a: assert property (done_age_r <= 16'(DONE_HOLD))
    else $error("completion flag not self-cleared in time");
  start_edge_a: assert property ((clk_en && state_r == ST_IDLE && meter_enable && !en_q_r) |=> state_r == ST_RUN)
    else $error("enable rise did not start");
  stop_a: assert property ((clk_en && !meter_enable) |=> state_r == ST_IDLE && !measure_done_flag)
    else $error("enable low did not stop");
endmodule : level_meter_result_unit

// ### tb/level_meter_result_unit_test.sv
module level_meter_result_unit_test;
  timeunit 1ns;
  timeprecision 1ps;
  import lm_pkg::*;
  // Short hold keeps the continuous-mode check fast
  localparam int HOLD = 8;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic sample_tick = 1'b0;
  logic signed [15:0] ac_s [NUM_CH];
  logic signed [15:0] tx_s [NUM_CH];
  logic signed [15:0] rx_s [NUM_CH];
  logic [CH_W-1:0] ch = 2'h0;
  logic ac_sel = 1'b1;
  logic dc_path = 1'b0;
  logic filt = 1'b0;
  logic shape = 1'b0;
  logic nsrc = 1'b1;
  logic bsrc = 1'b1;
  logic gain = 1'b0;
  logic rect = 1'b0;
  logic osel = 1'b1;
  logic signed [15:0] off_w = 16'h0000;
  logic signed [15:0] ncoef = 16'h0000;
  logic signed [15:0] bcoef = 16'h0000;
  logic single = 1'b1;
  logic en = 1'b0;
  logic [CNT_W-1:0] cnt = 11'h000;
  logic [SHIFT_W-1:0] shift = 4'h0;
  logic [TH_W-1:0] th = 3'h0;
  logic [7:0] res_lo;
  logic [7:0] res_hi;
  logic done;
  logic over;
  int seed = 32'h68E0DA49;
  int miscompares = 0;
  int checks = 0;
  int sum_exp = 0;
  int fw1 = 0;
  int fw2 = 0;

  always #10 clk = ~clk;

  level_meter_result_unit #(.DONE_HOLD(HOLD)) DUT (
    .clk(clk), .rst_b(rst_b), .clk_en(1'b1), .sample_tick(sample_tick),
    .ac_sample(ac_s), .dc_tx_sample(tx_s), .dc_rx_sample(rx_s),
    .meter_channel_sel(ch), .ac_source_sel(ac_sel), .dc_path_sel(dc_path),
    .filter_enable(filt), .filter_shape_sel(shape), .notch_coef_src(nsrc),
    .bandpass_coef_src(bsrc), .gain_sel(gain), .rectifier_enable(rect),
    .offset_source_sel(osel), .offset_word(off_w), .notch_coef(ncoef),
    .bandpass_coef(bcoef), .single_mode(single), .meter_enable(en),
    .integration_count(cnt), .shift_code(shift), .threshold_code(th),
    .meter_result_low(res_lo), .meter_result_high(res_hi),
    .measure_done_flag(done), .over_threshold_flag(over)
  );

  task automatic end_sim();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  function automatic int rnd();
    return $random(seed) % 2048;
  endfunction : rnd

  function automatic int sat(input int v);
    return (v > 32767) ? 32767 : ((v < -32768) ? -32768 : v);
  endfunction : sat

  // Resonator state moves on every sample, even with the filter bypassed
  function automatic int cond(input int x);
    int s;
    int c;
    int w;
    int bp;
    s = sat(x - (osel ? 0 : int'(off_w)));
    c = shape ? (bsrc ? int'(BP_ROM_COEF) : int'(bcoef)) : (nsrc ? int'(NOTCH_ROM_COEF) : int'(ncoef));
    w = sat(s + ((c * fw1) >>> COEF_FRAC) - ((int'(POLE_R2) * fw2) >>> COEF_FRAC));
    bp = sat((w - fw2) >>> 1);
    fw2 = fw1;
    fw1 = w;
    if (filt) s = shape ? bp : sat(s - bp);
    if (gain) s = s * 16;
    s = sat(s);
    if (rect && s < 0) s = -s;
    return sat(s);
  endfunction : cond

  function automatic logic [15:0] scale(input int s);
    int v;
    v = s >>> ((shift > 4'hB) ? 11 : int'(shift));
    if (v > 32767) v = 32767;
    if (v < -32768) v = -32768;
    return v[15:0];
  endfunction : scale

  function automatic logic over_exp(input logic [15:0] r);
    int m;
    m = int'($signed(r));
    if (m < 0) m = -m;
    return m > int'(th) * 4096;
  endfunction : over_exp

  // Unselected channels and sources carry noise so a wrong pick shows up
  task automatic pulse(input int v);
    for (int c = 0; c < NUM_CH; c++) begin
      ac_s[c] = 16'(rnd());
      tx_s[c] = 16'(rnd());
      rx_s[c] = 16'(rnd());
    end
    if (ac_sel) ac_s[ch] = 16'(v);
    else if (dc_path) tx_s[ch] = 16'(v);
    else rx_s[ch] = 16'(v);
    sum_exp += cond(v);
    sample_tick = 1'b1;
    @(negedge clk);
    sample_tick = 1'b0;
  endtask : pulse

  task automatic wait_done();
    for (int i = 0; i < 40 && done !== 1'b1; i++) @(negedge clk);
    if (done !== 1'b1) begin
      miscompares++;
      end_sim();
    end
  endtask : wait_done

  task automatic meas(input int n, input int v, input bit rnd_v);
    cnt = 11'(n);
    sum_exp = 0;
    en = 1'b1;
    repeat (3) @(negedge clk);
    for (int i = 0; i <= n; i++) begin
      pulse(rnd_v ? rnd() : v);
      repeat (5) @(negedge clk);
    end
    wait_done();
    check({res_hi, res_lo}, scale(sum_exp));
    check(16'(over), 16'(over_exp(scale(sum_exp))));
  endtask : meas

  task automatic stop();
    en = 1'b0;
    repeat (2) @(negedge clk);
    check({res_hi, res_lo}, 16'h0000);
    check(16'({done, over}), 16'h0000);
  endtask : stop

  initial begin
    logic [15:0] held;
    int n;
    for (int c = 0; c < NUM_CH; c++) begin
      ac_s[c] = 16'h0000;
      tx_s[c] = 16'h0000;
      rx_s[c] = 16'h0000;
    end
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    check({res_hi, res_lo}, 16'h0000);
    th = 3'h1;
    for (int v = 4096; v <= 4097; v++) begin
      meas(0, v, 1'b0);
      held = {res_hi, res_lo};
      pulse(100);
      repeat (5) @(negedge clk);
      check({res_hi, res_lo}, held);
      check(16'(done), 16'h0001);
      stop();
    end
    $display("test threshold_single done");
    gain = 1'b1;
    th = 3'h7;
    // Full scale both ways, then the fold of negative full-scale samples
    for (int k = 0; k < 3; k++) begin
      rect = (k == 2);
      meas(1, (k == 0) ? 4000 : -4000, 1'b0);
      stop();
    end
    $display("test saturation done");
    for (int k = 0; k < 16; k++) begin
      ch = 2'($random(seed));
      ac_sel = 1'($random(seed));
      dc_path = 1'($random(seed));
      gain = 1'($random(seed));
      rect = 1'($random(seed));
      osel = ac_sel | 1'($random(seed));
      off_w = 16'(rnd() / 4);
      th = 3'($random(seed));
      shape = 1'($random(seed));
      filt = 1'($random(seed));
      nsrc = 1'($random(seed));
      bsrc = 1'($random(seed));
      ncoef = 16'($random(seed));
      bcoef = 16'($random(seed));
      shift = 4'(k);
      meas(int'($unsigned($random(seed)) % 4), 0, 1'b1);
      stop();
    end
    $display("test random done");
    single = 1'b0;
    gain = 1'b0;
    rect = 1'b0;
    ac_sel = 1'b1;
    osel = 1'b1;
    shift = 4'h0;
    th = 3'h0;
    cnt = 11'h000;
    sum_exp = 0;
    en = 1'b1;
    repeat (3) @(negedge clk);
    pulse(3000);
    n = 0;
    repeat (30) begin
      @(negedge clk);
      n += int'(done === 1'b1);
    end
    check(16'(n), 16'(HOLD));
    check({res_hi, res_lo}, scale(sum_exp));
    sum_exp = 0;
    pulse(-1200);
    repeat (5) @(negedge clk);
    check({res_hi, res_lo}, scale(sum_exp));
    check(16'(done), 16'h0001);
    stop();
    $display("test continuous done");
    end_sim();
  end
endmodule : level_meter_result_unit_test
